// *** core/store_arith_exec.sv ***
// execution unit: rotate, subtract with carry and word stores
// Functional notes
// - shift byte zero: destination and carry unchanged
// - byte nonzero, low five bits zero: carry takes bit 31
// - nonzero amount: rotate right, carry from bit amount minus one
// - subtract with carry: rd minus rm minus not carry, written back
// - negative is result bit 31, zero when result all zero
// - carry is not-borrow, overflow signed, both include incoming carry
// - chaining after plain subtract gives correct 64-bit difference
// - store multiple ascending register order, lowest to lowest address
// - start at base, plus four per listed register, one write each
// - completion adds four times set-bit count to base
// - on abort base keeps original value (implementation choice)
// - store multiple clears two low address bits, data not rotated
// - alignment checking on: misaligned word store raises exception
// - immediate store: base plus four times 5-bit offset
// - misaligned single store without checking writes rd unrotated at the unaligned address
// - register store: base plus second operand register
// - stack store: stack pointer plus four times 8-bit offset
`timescale 1ns/100ps
`default_nettype none

module store_arith_exec (
    // clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    // command port
    input  wire logic                     cmd_valid_i,
    input  wire exec_pkg::cmd_t           cmd_i,
    output logic                          cmd_ready_o,
    output logic                          done_o,
    // configuration
    input  wire logic                     align_chk_en_i,
    // register load port
    input  wire logic                     reg_we_i,
    input  wire logic [2:0]               reg_idx_i,
    input  wire logic [31:0]              reg_data_i,
    input  wire logic [31:0]              sp_data_i,
    input  wire logic                     sp_we_i,
    input  wire exec_pkg::flags_t         flags_data_i,
    input  wire logic                     flags_we_i,
    // state view
    output exec_pkg::flags_t              flags_o,
    output logic [255:0]                  regs_o,
    output logic [31:0]                   sp_o,
    // memory write port
    output logic                          mem_valid_o,
    output exec_pkg::mem_req_t            mem_req_o,
    input  wire logic                     mem_ready_i,
    input  wire logic                     mem_resp_i,
    input  wire logic                     mem_abort_i,
    // exceptions
    output logic                          align_fault_o,
    output logic                          data_abort_o
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [31:0]         regs_r [exec_pkg::REG_CNT];
    logic [31:0]         sp_r;
    exec_pkg::flags_t    flags_r;
    exec_pkg::state_t    state_r;
    exec_pkg::mem_req_t  req_r;
    logic                req_valid_r;
    logic [7:0]          list_r;
    logic [2:0]          base_r;
    logic                multi_r;
    logic                done_r;
    logic                align_r;
    logic                abort_r;
    logic [31:0]         stm_addr_r;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [2:0] first_set(input logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = exec_pkg::REG_CNT - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [31:0] bit_count(input logic [7:0] m);
        logic [31:0] n;
        n = 32'h0;
        for (int i = 0; i < exec_pkg::REG_CNT; i++) begin
            n = n + {31'h0, m[i]};
        end
        return n;
    endfunction

    function automatic logic misaligned(input logic [31:0] a);
        return a[exec_pkg::ALIGN_MSB:0] != 2'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // rotate right by register

    logic [31:0]  rd_val;
    logic [31:0]  rm_val;
    logic [31:0]  rs_val;
    logic [4:0]   rot_amt;
    logic [63:0]  rot_dbl;
    logic [31:0]  rot_res;
    logic         rot_c;

    assign rd_val  = regs_r[cmd_i.rd];
    assign rm_val  = regs_r[cmd_i.rm];
    assign rs_val  = regs_r[cmd_i.rm];
    assign rot_amt = rs_val[exec_pkg::ROT_AMT_MSB:exec_pkg::ROT_AMT_LSB];
    assign rot_dbl = {rd_val, rd_val} >> rot_amt;

    always_comb begin
        rot_res = rd_val;
        rot_c   = flags_r.c;
        if (rs_val[exec_pkg::ROT_LOW_MSB:0] == 8'h00) begin
            rot_res = rd_val;
            rot_c   = flags_r.c;
        end else if (rot_amt == 5'h00) begin
            rot_c   = rd_val[exec_pkg::SIGN_BIT];
        end else begin
            rot_res = rot_dbl[31:0];
            rot_c   = rd_val[rot_amt - 5'h1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // subtract with carry

    logic [32:0]  sbc_sum;
    logic [31:0]  sbc_res;
    exec_pkg::flags_t sbc_flags;

    // rd + ~rm + c: carry out is not-borrow, chains with plain subtract
    assign sbc_sum = {1'b0, rd_val} + {1'b0, ~rm_val}
                   + {32'h0, flags_r.c};
    assign sbc_res = sbc_sum[31:0];

    always_comb begin
        sbc_flags.n = sbc_res[exec_pkg::SIGN_BIT];
        sbc_flags.z = (sbc_res == 32'h0);
        sbc_flags.c = sbc_sum[32];
        sbc_flags.v = (rd_val[31] != rm_val[31])
                    && (sbc_res[31] != rd_val[31]);
    end

    ////////////////////////////////////////////////////////////////////////
    // single store address

    logic [31:0] str_addr;

    always_comb begin
        case (cmd_i.op)
            exec_pkg::OP_STR_I:
                str_addr = regs_r[cmd_i.rn]
                         + {25'h0, cmd_i.imm[4:0], 2'h0};
            exec_pkg::OP_STR_R:
                str_addr = regs_r[cmd_i.rn] + rm_val;
            exec_pkg::OP_STR_S:
                str_addr = sp_r + {22'h0, cmd_i.imm, 2'h0};
            default:
                str_addr = regs_r[cmd_i.rn];
        endcase
    end

    logic is_str;
    logic is_stm;
    logic accept;
    logic stm_base_bad;

    assign is_str = (cmd_i.op == exec_pkg::OP_STR_I)
                 || (cmd_i.op == exec_pkg::OP_STR_R)
                 || (cmd_i.op == exec_pkg::OP_STR_S);
    assign is_stm = (cmd_i.op == exec_pkg::OP_STM);
    assign cmd_ready_o = (state_r == exec_pkg::ST_IDLE);
    assign accept = cmd_valid_i && cmd_ready_o;
    assign stm_base_bad = misaligned(regs_r[cmd_i.rn]);

    logic [2:0]  nxt_idx;
    logic [7:0]  list_nxt;

    assign nxt_idx  = first_set(list_r);
    assign list_nxt = list_r & ~(8'h01 << nxt_idx);

    ////////////////////////////////////////////////////////////////////////
    // sequencer and memory request

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r     <= exec_pkg::ST_IDLE;
            req_valid_r <= 1'b0;
            req_r       <= '0;
            list_r      <= 8'h00;
            base_r      <= 3'h0;
            multi_r     <= 1'b0;
            stm_addr_r  <= exec_pkg::WORD_RESET;
        end else begin
            case (state_r)
                exec_pkg::ST_IDLE: begin
                    if (accept && is_str) begin
                        if (!(align_chk_en_i && misaligned(str_addr))) begin
                            // misaligned, unchecked: address passes as is
                            req_r.addr  <= str_addr;
                            req_r.data  <= rd_val;
                            req_valid_r <= 1'b1;
                            multi_r     <= 1'b0;
                            state_r     <= exec_pkg::ST_WAIT;
                        end
                    end else if (accept && is_stm && cmd_i.imm != 8'h00
                                 && !(align_chk_en_i && stm_base_bad)) begin
                        list_r     <= cmd_i.imm;
                        base_r     <= cmd_i.rn;
                        stm_addr_r <= {regs_r[cmd_i.rn][31:2], 2'h0};
                        multi_r    <= 1'b1;
                        state_r    <= exec_pkg::ST_STM;
                    end
                end
                exec_pkg::ST_STM: begin
                    // lowest listed register to lowest address
                    req_r.addr  <= stm_addr_r;
                    req_r.data  <= regs_r[nxt_idx];
                    req_valid_r <= 1'b1;
                    list_r      <= list_nxt;
                    stm_addr_r  <= stm_addr_r + exec_pkg::WORD_STEP;
                    state_r     <= exec_pkg::ST_WAIT;
                end
                exec_pkg::ST_WAIT: begin
                    if (req_valid_r && mem_ready_i) begin
                        req_valid_r <= 1'b0;
                    end
                    if (mem_resp_i) begin
                        if (mem_abort_i || !multi_r || list_r == 8'h00) begin
                            state_r <= exec_pkg::ST_IDLE;
                        end else begin
                            state_r <= exec_pkg::ST_STM;
                        end
                    end
                end
                default: begin
                    state_r <= exec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign mem_valid_o = req_valid_r;
    assign mem_req_o   = req_r;

    ////////////////////////////////////////////////////////////////////////
    // register file and flags

    logic stm_last_ok;
    assign stm_last_ok = (state_r == exec_pkg::ST_WAIT) && multi_r
                      && mem_resp_i && !mem_abort_i && list_r == 8'h00;

    logic [31:0] stm_count;
    logic [7:0]  stm_list_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stm_list_r <= 8'h00;
        end else if (accept && is_stm) begin
            stm_list_r <= cmd_i.imm;
        end
    end

    assign stm_count = bit_count(stm_list_r);

    generate
        for (genvar g = 0; g < exec_pkg::REG_CNT; g++) begin : g_reg
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    regs_r[g] <= exec_pkg::WORD_RESET;
                end else if (reg_we_i && reg_idx_i == 3'(g)) begin
                    regs_r[g] <= reg_data_i;
                end else if (stm_last_ok && base_r == 3'(g)) begin
                    // abort skips this, base keeps original value
                    regs_r[g] <= regs_r[g]
                               + (stm_count << exec_pkg::WORD_SHIFT);
                end else if (accept && cmd_i.rd == 3'(g)
                             && cmd_i.op == exec_pkg::OP_ROR) begin
                    regs_r[g] <= rot_res;
                end else if (accept && cmd_i.rd == 3'(g)
                             && cmd_i.op == exec_pkg::OP_SBC) begin
                    regs_r[g] <= sbc_res;
                end
            end
            assign regs_o[g*32 +: 32] = regs_r[g];
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_r <= exec_pkg::WORD_RESET;
        end else if (sp_we_i) begin
            sp_r <= sp_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_r <= '0;
        end else if (flags_we_i) begin
            flags_r <= flags_data_i;
        end else if (accept && cmd_i.op == exec_pkg::OP_ROR) begin
            flags_r.c <= rot_c;
        end else if (accept && cmd_i.op == exec_pkg::OP_SBC) begin
            flags_r <= sbc_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion and exceptions

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_r  <= 1'b0;
            align_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            align_r <= accept && align_chk_en_i
                    && ((is_str && misaligned(str_addr))
                        || (is_stm && stm_base_bad));
            abort_r <= (state_r == exec_pkg::ST_WAIT) && mem_resp_i
                    && mem_abort_i;
            done_r  <= (accept && !is_str && !is_stm)
                    || (accept && is_stm && cmd_i.imm == 8'h00)
                    || (accept && align_chk_en_i
                        && ((is_str && misaligned(str_addr))
                            || (is_stm && stm_base_bad)))
                    || ((state_r == exec_pkg::ST_WAIT) && mem_resp_i
                        && (mem_abort_i || !multi_r || list_r == 8'h00));
        end
    end

    assign done_o        = done_r;
    assign align_fault_o = align_r;
    assign data_abort_o  = abort_r;
    assign flags_o       = flags_r;
    assign sp_o          = sp_r;

endmodule

`default_nettype wire

// *** core/exec_pkg.sv ***
// shared types and constants for the store and arithmetic execution unit
package exec_pkg;

    localparam int WORD_W        = 32;
    localparam int REG_CNT       = 8;
    localparam int REG_IDX_W     = 3;
    localparam int ROT_AMT_LSB   = 0;
    localparam int ROT_AMT_MSB   = 4;
    localparam int ROT_LOW_MSB   = 7;
    localparam int SIGN_BIT      = 31;
    localparam int ALIGN_MSB     = 1;
    localparam int WORD_SHIFT    = 2;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam int REG_FILE_RST_NOTE = 0;

    // operation codes presented on the command port
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_ROR   = 3'h1,
        OP_SBC   = 3'h2,
        OP_STM   = 3'h3,
        OP_STR_I = 3'h4,
        OP_STR_R = 3'h5,
        OP_STR_S = 3'h6
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [2:0] rd;
        logic [2:0] rn;
        logic [2:0] rm;
        logic [7:0] imm;
    } cmd_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } mem_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STM  = 3'b010,
        ST_WAIT = 3'b100
    } state_t;

endpackage

// *** verification/store_arith_exec_sva.sv ***
// port checks for the execution unit
`timescale 1ns/100ps
`default_nettype none
module store_arith_exec_sva (
    // clock and reset
    input wire logic               mclk_i,
    input wire logic               rst_n_i,
    // command and state
    input wire logic               cmd_valid_i,
    input wire exec_pkg::cmd_t     cmd_i,
    input wire logic               cmd_ready_o,
    input wire logic               done_o,
    input wire logic               align_chk_en_i,
    input wire exec_pkg::flags_t   flags_o,
    input wire logic [255:0]       regs_o,
    // memory and exceptions
    input wire logic               mem_valid_o,
    input wire exec_pkg::mem_req_t mem_req_o,
    input wire logic               mem_ready_i,
    input wire logic               mem_resp_i,
    input wire logic               mem_abort_i,
    input wire logic               align_fault_o,
    input wire logic               data_abort_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    exec_pkg::cmd_t cur_r;
    // command last accepted
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_r <= '0;
        end else if (cmd_valid_i && cmd_ready_o) begin
            cur_r <= cmd_i;
        end
    end
    sequence take_s;
        cmd_valid_i && cmd_ready_o;
    endsequence
    sequence alu_s;
        take_s ##0 cmd_i.op inside {exec_pkg::OP_ROR, exec_pkg::OP_SBC};
    endsequence
    sequence str_s;
        take_s ##0 cmd_i.op[2] && !align_chk_en_i;
    endsequence
    alu_done_a: assert property (alu_s |=> done_o && !mem_valid_o)
        else $error("alu result late");
    str_issue_a: assert property (str_s |=> mem_valid_o)
        else $error("store not issued");
    req_hold_a: assert property (mem_valid_o && !mem_ready_i
        |=> mem_valid_o && $stable(mem_req_o)) else $error("request moved");
    stm_word_a: assert property (mem_valid_o && cur_r.op == exec_pkg::OP_STM
        |-> mem_req_o.addr[1:0] == 2'h0) else $error("stm odd");
    chk_align_a: assert property (mem_valid_o && align_chk_en_i
        |-> mem_req_o.addr[1:0] == 2'h0) else $error("misaligned write");
    fault_end_a: assert property (align_fault_o |-> done_o)
        else $error("fault without end");
    str_done_a: assert property (mem_resp_i && cur_r.op[2] |=> done_o)
        else $error("store end late");
    abort_flag_a: assert property (mem_resp_i && mem_abort_i |=> data_abort_o)
        else $error("abort lost");
    sbc_nz_a: assert property (done_o && cur_r.op == exec_pkg::OP_SBC
        |-> flags_o.n == regs_o[cur_r.rd*32+31] && flags_o.z ==
        (regs_o[cur_r.rd*32+:32] == 32'h0)) else $error("sbc nz wrong");
    busy_a: assert property (mem_valid_o |-> !cmd_ready_o)
        else $error("ready while busy");
endmodule
bind store_arith_exec store_arith_exec_sva chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .align_chk_en_i(align_chk_en_i), .flags_o(flags_o), .regs_o(regs_o),
    .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
    .mem_ready_i(mem_ready_i), .mem_resp_i(mem_resp_i),
    .mem_abort_i(mem_abort_i), .align_fault_o(align_fault_o),
    .data_abort_o(data_abort_o));
`default_nettype wire

// *** verification/mem_model.sv ***
// memory side answering word writes after a set delay
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    // clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    // request
    input  wire logic               mem_valid_i,
    input  wire exec_pkg::mem_req_t mem_req_i,
    // bench control
    input  wire logic [3:0]         wait_i,
    input  wire logic               abort_i,
    // answer
    output var  logic               ready_o,
    output var  logic               resp_o,
    output var  logic               abort_o
);
    exec_pkg::mem_req_t log_q [$];
    logic [3:0]         cnt_r;
    logic               pend_r;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'h0;
            resp_o  <= 1'h0;
            abort_o <= 1'h1;
            pend_r  <= 1'h0;
            cnt_r   <= 4'h0;
        end else begin
            ready_o <= 1'h0;
            resp_o  <= pend_r;
            // abort means nothing outside a response
            abort_o <= pend_r ? abort_i : 1'h1;
            pend_r  <= 1'h0;
            if (mem_valid_i && !ready_o && !pend_r) begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == wait_i) begin
                    ready_o <= 1'h1;
                    pend_r  <= 1'h1;
                    cnt_r   <= 4'h0;
                    log_q.push_back(mem_req_i);
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/store_arith_exec_tb_top.sv ***
// self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module store_arith_exec_tb_top;
    logic               mclk_i = 1'h0;
    logic               rst_n_i = 1'h0;
    logic               cmd_valid_i = 1'h0;
    exec_pkg::cmd_t     cmd_i = '0;
    logic               align_chk_en_i = 1'h0;
    logic               reg_we_i = 1'h0;
    logic [2:0]         reg_idx_i = 3'h0;
    logic [31:0]        reg_data_i = 32'h0;
    logic [31:0]        sp_data_i = 32'h0;
    logic               sp_we_i = 1'h0;
    exec_pkg::flags_t   flags_data_i = '0;
    logic               flags_we_i = 1'h0;
    logic [3:0]         wait_r = 4'h0;
    logic               abort_r = 1'h0;
    logic               cmd_ready_o, done_o, mem_valid_o, align_fault_o;
    logic               mem_ready_i, mem_resp_i, mem_abort_i, data_abort_o;
    exec_pkg::flags_t   flags_o;
    logic [255:0]       regs_o;
    logic [31:0]        sp_o;
    exec_pkg::mem_req_t mem_req_o;
    logic               flt, abt;
    int                 n_fail = 0;
    int                 n_compared = 0;
    localparam logic [31:0] D = 32'h5A5A_C3C3;

    store_arith_exec uut (.*);
    mem_model mem (.mclk_i, .rst_n_i, .mem_valid_i(mem_valid_o),
        .mem_req_i(mem_req_o), .wait_i(wait_r), .abort_i(abort_r),
        .ready_o(mem_ready_i), .resp_o(mem_resp_i), .abort_o(mem_abort_i));

    always #2 mclk_i = ~mclk_i;

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [31:0] rg(input int i);
        return regs_o[i*32+:32];
    endfunction
    task automatic setr(input logic [2:0] i, input logic [31:0] v);
        @(posedge mclk_i);
        reg_we_i <= 1'h1;
        reg_idx_i <= i;
        reg_data_i <= v;
        @(posedge mclk_i);
        reg_we_i <= 1'h0;
    endtask
    // flags and a fixed stack pointer
    task automatic ld(input exec_pkg::flags_t f);
        @(posedge mclk_i);
        {flags_we_i, sp_we_i} <= 2'h3;
        flags_data_i <= f;
        sp_data_i <= 32'h0000_2000;
        @(posedge mclk_i);
        {flags_we_i, sp_we_i} <= 2'h0;
    endtask
    task automatic run(input exec_pkg::op_t op, input logic [2:0] d, n, m,
                       input logic [7:0] im);
        int k;
        while (cmd_ready_o !== 1'h1) @(posedge mclk_i);
        @(posedge mclk_i);
        cmd_valid_i <= 1'h1;
        cmd_i <= '{op, d, n, m, im};
        @(posedge mclk_i);
        cmd_valid_i <= 1'h0;
        {flt, abt} = 2'h0;
        for (k = 0; k < 60; k++) begin
            #1;
            flt |= align_fault_o;
            abt |= data_abort_o;
            if (done_o === 1'h1 || abt) break;
            @(posedge mclk_i);
        end
        if (k == 60) chk(32'h0, 32'h1, "no end");
    endtask
    task automatic lw(input int n, k, input logic [31:0] a, d);
        chk(mem.log_q.size(), n, "writes");
        chk(mem.log_q[k].addr, a, "address");
        chk(mem.log_q[k].data, d, "data");
    endtask
    task automatic t_ror;
        logic [31:0] amt [3] = '{32'h100, 32'h20, 32'h4};
        logic [31:0] res [3] = '{32'h8000_0018, 32'h8000_0018, 32'h8800_0001};
        logic        cy [3] = '{1'h0, 1'h1, 1'h1};
        for (int i = 0; i < 3; i++) begin
            ld('0);
            setr(3'h1, 32'h8000_0018);
            setr(3'h2, amt[i]);
            run(exec_pkg::OP_ROR, 3'h1, 3'h0, 3'h2, 8'h0);
            chk(rg(1), res[i], "ror value");
            chk(flags_o.c, cy[i], "ror carry");
        end
        $display("ror test ends");
    endtask
    task automatic t_sbc;
        ld(4'h2);
        setr(3'h0, 32'h0);
        setr(3'h1, 32'h1);
        setr(3'h2, 32'h1);
        setr(3'h3, 32'h0);
        run(exec_pkg::OP_SBC, 3'h0, 3'h0, 3'h2, 8'h0);
        chk(flags_o, 4'h8, "low flags");
        run(exec_pkg::OP_SBC, 3'h1, 3'h0, 3'h3, 8'h0);
        chk(flags_o, 4'h6, "high flags");
        chk(rg(1), 32'h0, "high word");
        chk(rg(0), 32'hFFFF_FFFF, "low word");
        ld(4'h2);
        setr(3'h4, 32'h8000_0000);
        setr(3'h5, 32'h1);
        run(exec_pkg::OP_SBC, 3'h4, 3'h0, 3'h5, 8'h0);
        chk(rg(4), 32'h7FFF_FFFF, "ovf value");
        chk(flags_o, 4'h3, "ovf flags");
        $display("sbc test ends");
    endtask
    task automatic t_stm;
        wait_r <= 4'h2;
        setr(3'h0, 32'hA000_0000);
        setr(3'h2, 32'hA000_0002);
        setr(3'h7, 32'hA000_0007);
        setr(3'h5, 32'h0000_0103);
        mem.log_q.delete();
        run(exec_pkg::OP_STM, 3'h0, 3'h5, 3'h0, 8'h85);
        lw(3, 0, 32'h100, 32'hA000_0000);
        lw(3, 1, 32'h104, 32'hA000_0002);
        lw(3, 2, 32'h108, 32'hA000_0007);
        chk(rg(5), 32'h10F, "writeback");
        mem.log_q.delete();
        run(exec_pkg::OP_STM, 3'h0, 3'h5, 3'h0, 8'h0);
        chk(mem.log_q.size(), 0, "empty list");
        chk(rg(5), 32'h10F, "empty base");
        $display("stm test ends");
    endtask
    task automatic t_str;
        wait_r <= 4'h0;
        ld('0);
        setr(3'h1, 32'h1000);
        setr(3'h2, 32'h24);
        setr(3'h3, D);
        mem.log_q.delete();
        run(exec_pkg::OP_STR_I, 3'h3, 3'h1, 3'h0, 8'hFF);
        run(exec_pkg::OP_STR_R, 3'h3, 3'h1, 3'h2, 8'h0);
        run(exec_pkg::OP_STR_S, 3'h3, 3'h0, 3'h0, 8'hFF);
        lw(3, 0, 32'h107C, D);
        lw(3, 1, 32'h1024, D);
        lw(3, 2, 32'h23FC, D);
        chk(sp_o, 32'h0000_2000, "stack pointer kept");
        $display("store test ends");
    endtask
    task automatic t_flt;
        setr(3'h2, 32'h22);
        align_chk_en_i <= 1'h1;
        mem.log_q.delete();
        run(exec_pkg::OP_STR_R, 3'h3, 3'h1, 3'h2, 8'h0);
        chk(flt, 1'h1, "str fault");
        run(exec_pkg::OP_STM, 3'h0, 3'h5, 3'h0, 8'h01);
        chk(flt, 1'h1, "stm fault");
        chk(mem.log_q.size(), 0, "faulted writes");
        @(posedge mclk_i);
        align_chk_en_i <= 1'h0;
        run(exec_pkg::OP_STR_R, 3'h3, 3'h1, 3'h2, 8'h0);
        lw(1, 0, 32'h1022, D);
        $display("alignment test ends");
    endtask
    task automatic t_abt;
        wait_r <= 4'h1;
        abort_r <= 1'h1;
        setr(3'h5, 32'h200);
        mem.log_q.delete();
        run(exec_pkg::OP_STM, 3'h0, 3'h5, 3'h0, 8'h07);
        chk(abt, 1'h1, "abort seen");
        chk(rg(5), 32'h200, "abort base");
        abort_r <= 1'h0;
        run(exec_pkg::OP_STR_I, 3'h3, 3'h1, 3'h0, 8'h0);
        lw(2, 1, 32'h1000, D);
        $display("abort test ends");
    endtask
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        t_ror();
        t_sbc();
        t_stm();
        t_str();
        t_flt();
        t_abt();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
